//--- src/baa_core.sv
// Four-phase execution datapath for the byte add and AND instructions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Literal add: W plus literal into W, updating all five flags.
// - File add: W plus file register into the selected destination.
// - File add with carry: W plus carry plus file register into destination.
// - Literal AND: W AND literal into W, only N and Z change.
// - File AND: W AND file register into destination, only N and Z change.
// - Destination bit 0 writes W; 1 writes back to the file register.
// - Access bit 0 uses access bank; 1 uses bank select register.
// - Extended set, access bit 0, address up to 95 uses indexed offset mode.
// - All adds update negative, overflow, carry, digit carry and zero flags.
// - Each instruction is one word, one cycle of four phases.
// - File add with destination 1 stores the sum into the file register.
module baa_core (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_in,
    output logic             instr_ready_out,
    output logic             done_out,
    output logic      [11:0] file_addr_out,
    output logic             file_indexed_out,
    output logic             file_rd_out,
    input  wire logic [7:0]  file_rdata_in,
    output logic             file_wr_out,
    output logic      [7:0]  file_wdata_out,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out
);

    baa_pkg::baa_phase_t phase_q;
    baa_pkg::baa_op_t    op_q;
    logic [15:0] instr_q;
    logic [7:0]  acc_q;
    logic [4:0]  status_q;
    logic [3:0]  bank_q;
    logic        ext_q;
    logic [7:0]  opa_q;
    logic [7:0]  opb_q;
    logic        cin_q;
    logic [7:0]  result_q;
    logic [4:0]  flags_q;
    logic [7:0]  rdata_q;
    logic        accept;
    logic        is_lit;
    logic        is_and;
    logic        is_add;
    logic        dest_file;
    logic [7:0]  fld_f;
    logic        fld_a;
    logic [7:0]  alu_b;
    logic        alu_cin;
    logic [7:0]  alu_res;
    logic        alu_c;
    logic        alu_dc;
    logic        alu_ov;
    logic        alu_n;
    logic        alu_z;

    ////////////////////////////////////////////////////////////////////////////
    // Handshake and decoded fields.
    assign accept          = instr_valid_in && instr_ready_out;
    assign instr_ready_out = (phase_q == baa_pkg::PH_IDLE) || (phase_q == baa_pkg::PH_Q4);
    assign done_out        = (phase_q == baa_pkg::PH_Q4);
    assign is_lit          = (op_q == baa_pkg::OP_LIT_ADD) || (op_q == baa_pkg::OP_LIT_AND);
    assign is_and          = (op_q == baa_pkg::OP_LIT_AND) || (op_q == baa_pkg::OP_FILE_AND);
    assign is_add          = (op_q == baa_pkg::OP_LIT_ADD) || (op_q == baa_pkg::OP_FILE_ADD)
                             || (op_q == baa_pkg::OP_FILE_ADDC);
    assign dest_file       = !is_lit && (op_q != baa_pkg::OP_NONE)
                             && instr_q[baa_pkg::DEST_BIT];
    assign fld_f           = instr_q[7:0];
    assign fld_a           = instr_q[baa_pkg::ACCESS_BIT];
    assign alu_b           = is_lit ? fld_f : file_rdata_in;
    assign alu_cin         = (op_q == baa_pkg::OP_FILE_ADDC) && status_q[baa_pkg::FLAG_C];

    baa_alu u_alu (
        .a_in             (acc_q),
        .b_in             (alu_b),
        .carry_in         (alu_cin),
        .and_in           (is_and),
        .result_out       (alu_res),
        .carry_out        (alu_c),
        .nibble_carry_out (alu_dc),
        .signed_wrap_out  (alu_ov),
        .neg_out          (alu_n),
        .zero_out         (alu_z)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequencer: decode, read operand, process, write destination.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= baa_pkg::PH_IDLE;
        end else begin
            case (phase_q)
                baa_pkg::PH_IDLE: begin
                    phase_q <= accept ? baa_pkg::PH_Q1 : baa_pkg::PH_IDLE;
                end
                baa_pkg::PH_Q1: phase_q <= baa_pkg::PH_Q2;
                baa_pkg::PH_Q2: phase_q <= baa_pkg::PH_Q3;
                baa_pkg::PH_Q3: phase_q <= baa_pkg::PH_Q4;
                baa_pkg::PH_Q4: begin
                    phase_q <= accept ? baa_pkg::PH_Q1 : baa_pkg::PH_IDLE;
                end
                default: phase_q <= baa_pkg::PH_IDLE;
            endcase
        end
    end

    // Instruction word capture; one word per instruction.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_q <= 16'h0000;
            op_q    <= baa_pkg::OP_NONE;
        end else if (accept) begin
            instr_q <= instr_in;
            op_q    <= baa_pkg::baa_decode(instr_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand address formation during decode.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            file_addr_out    <= 12'h000;
            file_indexed_out <= 1'b0;
            file_rd_out      <= 1'b0;
        end else if (phase_q == baa_pkg::PH_Q1) begin
            file_rd_out      <= !is_lit && (op_q != baa_pkg::OP_NONE);
            file_indexed_out <= !fld_a && ext_q && (fld_f <= baa_pkg::INDEX_LIMIT);
            if (fld_a) begin
                file_addr_out <= {bank_q, fld_f};
            end else if (fld_f < baa_pkg::ACCESS_SPLIT) begin
                file_addr_out <= {baa_pkg::ACCESS_LOW, fld_f};
            end else begin
                file_addr_out <= {baa_pkg::ACCESS_HIGH, fld_f};
            end
        end else begin
            file_rd_out <= 1'b0;
        end
    end

    // Process data: operands and results are held for the write phase.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            opa_q    <= 8'h00;
            opb_q    <= 8'h00;
            cin_q    <= 1'b0;
            result_q <= 8'h00;
            flags_q  <= 5'h00;
        end else if (phase_q == baa_pkg::PH_Q3) begin
            opa_q    <= acc_q;
            opb_q    <= alu_b;
            cin_q    <= alu_cin;
            result_q <= alu_res;
            flags_q  <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
        end
    end

    // File register write-back strobe and data.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            file_wr_out    <= 1'b0;
            file_wdata_out <= 8'h00;
        end else if (phase_q == baa_pkg::PH_Q3) begin
            file_wr_out    <= dest_file;
            file_wdata_out <= alu_res;
        end else begin
            file_wr_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Working register; the write phase wins over a software write.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_q <= baa_pkg::ACC_RST;
        end else if (phase_q == baa_pkg::PH_Q4 && op_q != baa_pkg::OP_NONE && !dest_file) begin
            acc_q <= result_q;
        end else if (reg_wr_in && reg_addr_in == baa_pkg::REG_ACC) begin
            acc_q <= reg_wdata_in;
        end
    end

    // Status flags; adds change all five, AND changes only N and Z.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= baa_pkg::STATUS_RST;
        end else if (phase_q == baa_pkg::PH_Q4 && is_add) begin
            status_q <= flags_q;
        end else if (phase_q == baa_pkg::PH_Q4 && is_and) begin
            status_q[baa_pkg::FLAG_N] <= flags_q[baa_pkg::FLAG_N];
            status_q[baa_pkg::FLAG_Z] <= flags_q[baa_pkg::FLAG_Z];
        end else if (reg_wr_in && reg_addr_in == baa_pkg::REG_STATUS) begin
            status_q <= reg_wdata_in[4:0];
        end
    end

    // Bank select and extended set enable.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bank_q <= baa_pkg::BANK_RST;
            ext_q  <= baa_pkg::EXT_RST;
        end else if (reg_wr_in && reg_addr_in == baa_pkg::REG_BANK) begin
            bank_q <= reg_wdata_in[3:0];
        end else if (reg_wr_in && reg_addr_in == baa_pkg::REG_CTRL) begin
            ext_q <= reg_wdata_in[baa_pkg::CTRL_EXT];
        end
    end

    // Register read port; unmapped offsets read as zero.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                baa_pkg::REG_ACC:    rdata_q <= acc_q;
                baa_pkg::REG_STATUS: rdata_q <= {3'h0, status_q};
                baa_pkg::REG_BANK:   rdata_q <= {4'h0, bank_q};
                baa_pkg::REG_CTRL:   rdata_q <= {7'h00, ext_q};
                default:             rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    phase_order_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        phase_q == baa_pkg::PH_Q1 |=> phase_q == baa_pkg::PH_Q2 ##1 phase_q == baa_pkg::PH_Q3
            ##1 phase_q == baa_pkg::PH_Q4)
        else $error("Instruction phases out of order.");

    lit_add_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && op_q == baa_pkg::OP_LIT_ADD |=> acc_q == $past(opa_q) + $past(opb_q))
        else $error("Literal add did not reach the working register.");

    file_add_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && op_q == baa_pkg::OP_FILE_ADD && dest_file
            |-> file_wr_out && file_wdata_out == opa_q + opb_q)
        else $error("File add sum not written back.");

    carry_add_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && op_q == baa_pkg::OP_FILE_ADDC |-> result_q == opa_q + opb_q + {7'h00, cin_q})
        else $error("Add with carry result wrong.");

    lit_and_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && op_q == baa_pkg::OP_LIT_AND
            && !(reg_wr_in && reg_addr_in == baa_pkg::REG_STATUS)
            |=> acc_q == ($past(opa_q) & $past(opb_q))
            && status_q[baa_pkg::FLAG_C] == $past(status_q[baa_pkg::FLAG_C])
            && status_q[baa_pkg::FLAG_OV] == $past(status_q[baa_pkg::FLAG_OV]))
        else $error("Literal AND result or flags wrong.");

    file_and_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && op_q == baa_pkg::OP_FILE_AND
            && !(reg_wr_in && reg_addr_in == baa_pkg::REG_STATUS)
            |=> status_q[baa_pkg::FLAG_DC] == $past(status_q[baa_pkg::FLAG_DC])
            && status_q[baa_pkg::FLAG_Z] == ($past(result_q) == 8'h00))
        else $error("File AND flag update wrong.");

    dest_acc_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && !is_lit && op_q != baa_pkg::OP_NONE && !instr_q[baa_pkg::DEST_BIT]
            |-> !file_wr_out ##1 acc_q == $past(result_q))
        else $error("Destination zero did not select the working register.");

    bank_map_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        phase_q == baa_pkg::PH_Q2 && fld_a |-> file_addr_out[11:8] == $past(bank_q))
        else $error("Bank select not applied.");

    indexed_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        phase_q == baa_pkg::PH_Q2 |-> file_indexed_out
            == ($past(ext_q) && !fld_a && fld_f <= baa_pkg::INDEX_LIMIT))
        else $error("Indexed mode selection wrong.");

    add_flags_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && is_add |=> status_q[baa_pkg::FLAG_Z] == ($past(result_q) == 8'h00)
            && status_q[baa_pkg::FLAG_N] == $past(result_q[7]))
        else $error("Add flags not updated.");

    wb_file_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(file_wr_out) |-> done_out && instr_q[baa_pkg::DEST_BIT] && !is_lit)
        else $error("File write without destination one.");

    carry_flag_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        done_out && is_add |-> flags_q[baa_pkg::FLAG_C]
            == (({1'b0, opa_q} + {1'b0, opb_q} + {8'h00, cin_q}) > 9'h0FF))
        else $error("Carry flag wrong.");

endmodule // baa_core

`default_nettype wire

//--- src/baa_pkg.sv
// Shared constants, types and opcode decoding for the byte add and AND datapath.
package baa_pkg;

    // Register port offsets.
    localparam logic [3:0] REG_ACC    = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_BANK   = 4'h2;
    localparam logic [3:0] REG_CTRL   = 4'h3;

    // Status flag positions.
    localparam int FLAG_C  = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N  = 4;

    // Control field positions.
    localparam int CTRL_EXT = 0;

    // Reset values.
    localparam logic [7:0] ACC_RST    = 8'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [3:0] BANK_RST   = 4'h0;
    localparam logic       EXT_RST    = 1'b0;

    // Instruction fields.
    localparam int DEST_BIT   = 9;
    localparam int ACCESS_BIT = 8;

    // Opcodes: literal forms compare the top byte, file forms the top six bits.
    localparam logic [7:0] OPC_LIT_ADD   = 8'h0F;
    localparam logic [7:0] OPC_LIT_AND   = 8'h0B;
    localparam logic [5:0] OPC_FILE_ADD  = 6'h09;
    localparam logic [5:0] OPC_FILE_ADDC = 6'h08;
    localparam logic [5:0] OPC_FILE_AND  = 6'h05;

    // Access bank split and indexed offset limit.
    localparam logic [7:0] INDEX_LIMIT  = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH  = 4'hF;
    localparam logic [3:0] ACCESS_LOW   = 4'h0;

    typedef enum logic [2:0] {
        OP_NONE, OP_LIT_ADD, OP_FILE_ADD, OP_FILE_ADDC, OP_LIT_AND, OP_FILE_AND
    } baa_op_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_Q1   = 3'b001,
        PH_Q2   = 3'b011,
        PH_Q3   = 3'b010,
        PH_Q4   = 3'b110
    } baa_phase_t;

    // Maps an instruction word to the operation it selects.
    function automatic baa_op_t baa_decode(input logic [15:0] word);
        baa_op_t op;
        op = OP_NONE;
        if (word[15:8] == OPC_LIT_ADD) begin
            op = OP_LIT_ADD;
        end else if (word[15:8] == OPC_LIT_AND) begin
            op = OP_LIT_AND;
        end else if (word[15:10] == OPC_FILE_ADD) begin
            op = OP_FILE_ADD;
        end else if (word[15:10] == OPC_FILE_ADDC) begin
            op = OP_FILE_ADDC;
        end else if (word[15:10] == OPC_FILE_AND) begin
            op = OP_FILE_AND;
        end
        return op;
    endfunction

endpackage

//--- src/baa_alu.sv
// Eight-bit adder and AND unit with status flag generation.
`timescale 1ns/1ps
`default_nettype none

module baa_alu (
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic       carry_in,
    input  wire logic       and_in,
    output logic      [7:0] result_out,
    output logic            carry_out,
    output logic            nibble_carry_out,
    output logic            signed_wrap_out,
    output logic            neg_out,
    output logic            zero_out
);

    logic [4:0] low_sum;
    logic [4:0] high_sum;
    logic [7:0] sum;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        low_sum  = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
        high_sum = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, low_sum[4]};
        sum      = {high_sum[3:0], low_sum[3:0]};
        if (and_in) begin
            result_out = a_in & b_in;
        end else begin
            result_out = sum;
        end
        carry_out        = high_sum[4];
        nibble_carry_out = low_sum[4];
        signed_wrap_out  = (a_in[7] == b_in[7]) && (sum[7] != a_in[7]);
        neg_out          = result_out[7];
        zero_out         = (result_out == 8'h00);
    end

endmodule // baa_alu

`default_nettype wire

//--- bench/baa_file_model.sv
// Behavioural data register file facing the datapath's file port.
`timescale 1ns/1ps
`default_nettype none

module baa_file_model (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        set_in,
    input  wire logic [11:0] set_addr_in,
    input  wire logic [7:0]  set_data_in,
    input  wire logic [11:0] peek_addr_in,
    output logic      [7:0]  peek_data_out
);
    logic [7:0] mem_q [0:4095];

    assign peek_data_out = mem_q[peek_addr_in];

    // Read data stand one cycle after the strobe, then turn to a changing pattern.
    always_ff @(posedge clk_in) begin
        if (rd_in) begin
            rdata_out <= mem_q[addr_in];
        end else begin
            rdata_out <= ~rdata_out;
        end
        if (wr_in) begin
            mem_q[addr_in] <= wdata_in;
        end
        if (set_in) begin
            mem_q[set_addr_in] <= set_data_in;
        end
    end
endmodule // baa_file_model

`default_nettype wire

//--- bench/byte_add_and_alu_bench.sv
// Self-checking bench for the byte add and AND datapath.
`timescale 1ns/1ps
`default_nettype none

module byte_add_and_alu_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        iv = 1'b0;
    logic [15:0] iw = 16'h0000;
    logic        rdy, done, frd, fwr, fidx;
    logic [11:0] faddr;
    logic [7:0]  frdata, fwdata, rrdata, pdata;
    logic [3:0]  raddr = 4'h0;
    logic [7:0]  rwdata = 8'h00;
    logic        rwr = 1'b0;
    logic        rrd = 1'b0;
    logic        mset = 1'b0;
    logic [11:0] maddr = 12'h000;
    logic [11:0] paddr = 12'h000;
    logic [7:0]  mdata = 8'h00;
    logic [7:0]  w_e = 8'h00;
    logic [4:0]  st_e = 5'h00;
    logic [3:0]  bank_e = 4'h0;
    logic        ext_e = 1'b0;
    logic        pend = 1'b0;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    baa_core DUT (.clk_in(clk), .rst_in(rst), .instr_valid_in(iv), .instr_in(iw),
        .instr_ready_out(rdy), .done_out(done), .file_addr_out(faddr),
        .file_indexed_out(fidx), .file_rd_out(frd), .file_rdata_in(frdata),
        .file_wr_out(fwr), .file_wdata_out(fwdata), .reg_addr_in(raddr),
        .reg_wdata_in(rwdata), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rrdata));

    baa_file_model file_model (.clk_in(clk), .rd_in(frd), .wr_in(fwr), .addr_in(faddr),
        .wdata_in(fwdata), .rdata_out(frdata), .set_in(mset), .set_addr_in(maddr),
        .set_data_in(mdata), .peek_addr_in(paddr), .peek_data_out(pdata));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        rwr <= 1'b1;
        raddr <= a;
        rwdata <= d;
        @(posedge clk);
        rwr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        rrd <= 1'b1;
        raddr <= a;
        @(posedge clk);
        rrd <= 1'b0;
        @(negedge clk);
        check("read data", {8'h00, rrdata}, {8'h00, e});
        @(negedge clk);
        check("read idle", {8'h00, rrdata}, 16'h0000);
        @(posedge clk);
    endtask

    task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
        mset <= 1'b1;
        maddr <= a;
        mdata <= d;
        @(posedge clk);
        mset <= 1'b0;
        @(posedge clk);
    endtask

    task automatic set_ws(input logic [7:0] w, input logic [4:0] st);
        reg_wr(baa_pkg::REG_ACC, w);
        reg_wr(baa_pkg::REG_STATUS, {3'b000, st});
        w_e = w;
        st_e = st;
    endtask

    task automatic state_chk();
        reg_rd(baa_pkg::REG_ACC, w_e);
        reg_rd(baa_pkg::REG_STATUS, {3'b000, st_e});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [15:0] word, input logic chain, input logic [15:0] nxt);
        logic [7:0]  f, opd, r;
        logic [4:0]  h, ns;
        logic [8:0]  s;
        logic        fop, d, add, cin, idx;
        logic [11:0] ea;
        f = word[7:0];
        d = word[9];
        fop = word[15:12] != 4'h0;
        add = word[15:8] == 8'h0F || word[15:11] == 5'b00100;
        cin = word[15:10] == 6'b001000 && st_e[baa_pkg::FLAG_C];
        ea = word[8] ? {bank_e, f} : {(f < 8'h60) ? 4'h0 : 4'hF, f};
        idx = fop && !word[8] && ext_e && f <= 8'h5F;
        paddr = ea;
        opd = 8'h00;
        if (!pend) begin
            iv <= 1'b1;
            iw <= word;
            for (int k = 0; k < 10; k++) begin
                @(negedge clk);
                if (rdy === 1'b1) break;
            end
            @(posedge clk);
        end
        pend = chain;
        iv <= 1'b0;
        for (int n = 1; n <= 4; n++) begin
            @(negedge clk);
            if (n == 1) opd = fop ? pdata : f;
            check("done", {15'h0000, done}, {15'h0000, n == 4});
            check("ready", {15'h0000, rdy}, {15'h0000, n == 4});
            check("file read", {15'h0000, frd}, {15'h0000, fop && n == 2});
            if (n == 2 && fop) begin
                check("address", {4'h0, faddr}, {4'h0, ea});
                check("indexed", {15'h0000, fidx}, {15'h0000, idx});
            end
            if (n == 4) begin
                s = add ? {1'b0, w_e} + {1'b0, opd} + {8'h00, cin} : {1'b0, w_e & opd};
                h = {1'b0, w_e[3:0]} + {1'b0, opd[3:0]} + {4'h0, cin};
                r = s[7:0];
                ns = st_e;
                ns[baa_pkg::FLAG_N] = r[7];
                ns[baa_pkg::FLAG_Z] = r == 8'h00;
                if (add) begin
                    ns[baa_pkg::FLAG_C] = s[8];
                    ns[baa_pkg::FLAG_DC] = h[4];
                    ns[baa_pkg::FLAG_OV] = w_e[7] == opd[7] && r[7] != w_e[7];
                end
                check("file write", {15'h0000, fwr}, {15'h0000, fop && d});
                if (fop && d) check("write data", {8'h00, fwdata}, {8'h00, r});
                if (!(fop && d)) w_e = r;
                st_e = ns;
            end
            if (n < 4) @(posedge clk);
            if (n == 3 && chain) begin
                iv <= 1'b1;
                iw <= nxt;
            end
        end
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int a = 0; a < 4; a++) reg_rd(a[3:0], 8'h00);
        reg_wr(4'h9, 8'hFF);
        reg_rd(4'h9, 8'h00);
        reg_wr(baa_pkg::REG_BANK, 8'h03);
        bank_e = 4'h3;
        reg_rd(baa_pkg::REG_BANK, 8'h03);
        $display("test registers done");
    endtask

    task automatic t_lit();
        logic [7:0] wv [4] = '{8'h10, 8'h7F, 8'hFF, 8'h08};
        logic [7:0] kv [4] = '{8'h15, 8'h01, 8'h01, 8'h08};
        for (int i = 0; i < 4; i++) begin
            set_ws(wv[i], 5'h00);
            run({8'h0F, kv[i]}, 1'b0, 16'h0000);
            state_chk();
        end
        $display("test literal add done");
    endtask

    task automatic t_file();
        set_ws(8'h17, 5'h00);
        mem_set(12'h342, 8'hC2);
        run(16'h2542, 1'b0, 16'h0000);
        state_chk();
        run(16'h2742, 1'b0, 16'h0000);
        state_chk();
        check("stored sum", {8'h00, pdata}, 16'h009B);
        $display("test file add done");
    endtask

    task automatic t_addc();
        set_ws(8'h4D, 5'h01);
        mem_set(12'h302, 8'h02);
        run(16'h2102, 1'b1, 16'h2102);
        run(16'h2102, 1'b0, 16'h0000);
        state_chk();
        $display("test add with carry done");
    endtask

    task automatic t_and();
        set_ws(8'hA3, 5'h0F);
        run(16'h0B5F, 1'b0, 16'h0000);
        state_chk();
        mem_set(12'hF70, 8'h80);
        set_ws(8'hC3, 5'h0F);
        run(16'h1670, 1'b0, 16'h0000);
        state_chk();
        mem_set(12'hF70, 8'h3C);
        run(16'h1470, 1'b0, 16'h0000);
        state_chk();
        $display("test and done");
    endtask

    task automatic t_index();
        reg_wr(baa_pkg::REG_CTRL, 8'h01);
        ext_e = 1'b1;
        reg_rd(baa_pkg::REG_CTRL, 8'h01);
        mem_set(12'h05F, 8'h01);
        mem_set(12'hF60, 8'h02);
        mem_set(12'h310, 8'h03);
        mem_set(12'h010, 8'h04);
        set_ws(8'h00, 5'h00);
        run(16'h245F, 1'b0, 16'h0000);
        run(16'h2460, 1'b0, 16'h0000);
        run(16'h2510, 1'b0, 16'h0000);
        reg_wr(baa_pkg::REG_CTRL, 8'h00);
        ext_e = 1'b0;
        run(16'h2410, 1'b0, 16'h0000);
        state_chk();
        $display("test addressing done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_lit();
        t_file();
        t_addc();
        t_and();
        t_index();
        print_verdict();
    end
endmodule // byte_add_and_alu_bench

`default_nettype wire
